// ==== core/smbfl_consts.svh ====
`ifndef SMBFL_CONSTS_SVH
`define SMBFL_CONSTS_SVH
`define SMBFL_CMD_PASS 8'hE0
`define SMBFL_CMD_TLIST 8'hE1
`define SMBFL_CMD_COMPAT 8'hE2
`define SMBFL_CMD_REV 8'hE3
`define SMBFL_CMD_CAP 8'hE4
`define SMBFL_CMD_STAT 8'hE5
`define SMBFL_CMD_BOOT 8'hE6
`define SMBFL_CMD_DATA 8'hE7
`define SMBFL_BL_ENTER 8'h01
`define SMBFL_BL_ERASE 8'h02
`define SMBFL_BL_DONE 8'h03
`define SMBFL_BL_EXIT 8'h04
`define SMBFL_ST_ERASED 8'h01
`define SMBFL_ST_CRCBAD 8'h02
`define SMBFL_ST_SEQERR 8'h04
`define SMBFL_ST_RANGE 8'h08
`define SMBFL_ST_DOWN 8'h40
`define SMBFL_ST_BOOT 8'h80
`define SMBFL_ST_ERRS 8'h0F
`define SMBFL_CH_P 8'h70
`define SMBFL_CH_S 8'h73
`define SMBFL_CH_I 8'h69
`define SMBFL_PW_LEN 8'h04
`define SMBFL_PW_U 8'h55
`define SMBFL_PW_P 8'h50
`define SMBFL_PW_G 8'h47
`define SMBFL_PW_D 8'h44
`define SMBFL_CNT_TL 8'h03
`define SMBFL_CNT_CC 8'h20
`define SMBFL_CNT_REV 8'h07
`define SMBFL_CNT_CAP 8'h07
`define SMBFL_CNT_DT 8'h03
`define SMBFL_IX_REV 6'h20
`define SMBFL_IX_MAX 6'h27
`define SMBFL_IX_ET 6'h28
`define SMBFL_IX_BT 6'h2A
`define SMBFL_WI_PASS 8'h07
`define SMBFL_WI_BOOT 8'h04
`define SMBFL_WI_DHDR 8'h06
`define SMBFL_PEC_POLY 8'h07
`define SMBFL_CRC_POLY 16'h1021
`define SMBFL_CRC_INIT 16'h0000
`define SMBFL_A_CTRL 10'h000
`define SMBFL_A_STAT 10'h004
`define SMBFL_A_SEQ 10'h008
`define SMBFL_TGT_NONE 2'h3
`endif

// ==== core/smbfl_pkg.sv ====
package smbfl_pkg;
    typedef struct packed {
        logic start;
        logic stop;
        logic valid;
        logic [7:0] data;
    } smbfl_rx_t;
    typedef struct packed {
        logic valid;
        logic commit;
        logic abort;
        logic [1:0] tgt;
        logic [15:0] seq;
        logic [7:0] data;
    } smbfl_pkt_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ADR = 4'b0010,
        ST_WR = 4'b0100,
        ST_RD = 4'b1000
    } smbfl_state_t;
endpackage

// ==== core/smbfl_loader.sv ====
// Function
// - target list read returns count 3, one ASCII letter per processor, then PEC.
// - selector p primary, s secondary, i interface processor.
// - compatibility read returns count 32, 32 characters, then PEC.
// - revision read returns count 7, seven revision/date bytes, then PEC.
// - capability read: max bytes, erase ms, write us, app CRC, PEC.
// - status read returns one status byte and PEC, no count.
// - status bits: erased, crc bad, seq error, range, downstream, boot.
// - boot command data 1 enter, 2 erase, 3 done, 4 exit.
// - target byte ignored for enter and exit.
// - output switched off if still on during boot loading.
// - after erase, status reads 0x81.
// - data write carries seq, count, data, PEC; first seq zero.
// - each accepted packet increments expected sequence number.
// - data read returns count 3, seq LSB, MSB, status, PEC.
// - upgrade commands locked until password UPGD received.
// - done with valid image makes status read 0x80.
`timescale 1ns/1ns
`include "smbfl_consts.svh"
module smbfl_loader
    import smbfl_pkg::*;
#(
    parameter logic [2:0] DOWN_MASK = 3'b000,
    parameter logic [15:0] MAX_PKTS = 16'hFFFF
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire smbfl_rx_t rx,
    input wire logic tx_req,
    output logic [7:0] tx_data,
    output logic tx_valid,
    output smbfl_pkt_t pkt,
    output logic erase_req,
    output logic [1:0] erase_tgt,
    output logic soft_reboot,
    output logic wdog_reboot,
    input wire logic output_on,
    output logic output_off,
    input wire logic [9:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);
    function automatic logic [1:0] tsel(input logic [7:0] c);
        case (c)
            `SMBFL_CH_P: tsel = 2'h0;
            `SMBFL_CH_S: tsel = 2'h1;
            `SMBFL_CH_I: tsel = 2'h2;
            default: tsel = `SMBFL_TGT_NONE;
        endcase
    endfunction

    function automatic logic [7:0] crc8(input logic [7:0] c,
                                        input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ({r[6:0], 1'b0} ^ `SMBFL_PEC_POLY) : {r[6:0], 1'b0};
        end
        crc8 = r;
    endfunction

    function automatic logic [15:0] crc16(input logic [15:0] c,
                                          input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ({r[14:0], 1'b0} ^ `SMBFL_CRC_POLY)
                      : {r[14:0], 1'b0};
        end
        crc16 = r;
    endfunction

    smbfl_state_t st_q, st_d;
    logic [7:0] info_q [0:191];
    logic [7:0] info_d [0:191];
    logic [7:0] stat_q [0:2];
    logic [7:0] stat_d [0:2];
    logic [15:0] seq_q [0:2];
    logic [15:0] seq_d [0:2];
    logic [15:0] crc_q [0:2];
    logic [15:0] crc_d [0:2];
    logic [15:0] pcrc_q, pcrc_d;
    logic [7:0] pec_q, pec_d, wi_q, wi_d, txi_q, txi_d;
    logic [7:0] cmd_q, cmd_d, tgt_q, tgt_d, a0_q, a0_d, a1_q, a1_d;
    logic [7:0] cnt_q, cnt_d, txd_q, txd_d;
    logic pwok_q, pwok_d, unl_q, unl_d, off_q, off_d, txv_q, txv_d;
    logic ers_q, ers_d, sr_q, sr_d, wd_q, wd_d;
    logic [1:0] etg_q, etg_d;
    smbfl_pkt_t pkt_q, pkt_d;
    logic [31:0] rd_q, rd_d;
    logic on_m_q, on_s_q;
    logic [1:0] t;
    logic [7:0] rb, last, pw_exp;
    logic [5:0] ix;

    assign t = tsel(tgt_q);

    // answer byte for the current read position; last marks the PEC slot
    always_comb begin
        rb = 8'hFF;
        last = 8'h00;
        ix = 6'h00;
        case (cmd_q)
            `SMBFL_CMD_TLIST: begin
                last = `SMBFL_CNT_TL + 8'h01;
                case (txi_q)
                    8'h00: rb = `SMBFL_CNT_TL;
                    8'h01: rb = `SMBFL_CH_P;
                    8'h02: rb = `SMBFL_CH_S;
                    8'h03: rb = `SMBFL_CH_I;
                    default: rb = 8'hFF;
                endcase
            end
            `SMBFL_CMD_COMPAT: begin
                last = `SMBFL_CNT_CC + 8'h01;
                ix = 6'(txi_q - 8'h01);
                rb = (txi_q == 8'h00) ? `SMBFL_CNT_CC
                   : info_q[{t, ix}];
            end
            `SMBFL_CMD_REV: begin
                last = `SMBFL_CNT_REV + 8'h01;
                ix = 6'(txi_q - 8'h01) + `SMBFL_IX_REV;
                rb = (txi_q == 8'h00) ? `SMBFL_CNT_REV
                   : info_q[{t, ix}];
            end
            `SMBFL_CMD_CAP: begin
                last = `SMBFL_CNT_CAP + 8'h01;
                ix = 6'(txi_q - 8'h01) + `SMBFL_IX_MAX;
                case (txi_q)
                    8'h00: rb = `SMBFL_CNT_CAP;
                    8'h06: rb = crc_q[t][7:0];
                    8'h07: rb = crc_q[t][15:8];
                    default: rb = info_q[{t, ix}];
                endcase
            end
            `SMBFL_CMD_STAT: begin
                last = 8'h01;
                rb = stat_q[t];
            end
            `SMBFL_CMD_DATA: begin
                last = `SMBFL_CNT_DT + 8'h01;
                case (txi_q)
                    8'h00: rb = `SMBFL_CNT_DT;
                    8'h01: rb = seq_q[t][7:0];
                    8'h02: rb = seq_q[t][15:8];
                    default: rb = stat_q[t];
                endcase
            end
            default: rb = 8'hFF;
        endcase
        if (t == `SMBFL_TGT_NONE && cmd_q != `SMBFL_CMD_TLIST) begin
            rb = 8'hFF;
        end
        case (wi_q)
            8'h02: pw_exp = `SMBFL_PW_U;
            8'h03: pw_exp = `SMBFL_PW_P;
            8'h04: pw_exp = `SMBFL_PW_G;
            default: pw_exp = `SMBFL_PW_D;
        endcase
    end

    always_comb begin
        st_d = st_q;
        info_d = info_q;
        stat_d = stat_q;
        seq_d = seq_q;
        crc_d = crc_q;
        pcrc_d = pcrc_q;
        pec_d = pec_q;
        wi_d = wi_q;
        txi_d = txi_q;
        cmd_d = cmd_q;
        tgt_d = tgt_q;
        a0_d = a0_q;
        a1_d = a1_q;
        cnt_d = cnt_q;
        pwok_d = pwok_q;
        unl_d = unl_q;
        off_d = off_q;
        txd_d = txd_q;
        txv_d = 1'b0;
        ers_d = 1'b0;
        etg_d = etg_q;
        sr_d = 1'b0;
        wd_d = 1'b0;
        pkt_d = '0;
        pkt_d.tgt = t;
        pkt_d.seq = {a1_q, a0_q};
        rd_d = 32'h0;
        // software side
        if (reg_wr && reg_addr == `SMBFL_A_CTRL && reg_wdata[0]) begin
            unl_d = 1'b0;
        end
        if (reg_wr && reg_addr[9] && reg_addr[7:6] != `SMBFL_TGT_NONE) begin
            info_d[reg_addr[7:0]] = reg_wdata[7:0];
        end
        if (reg_rd) begin
            if (reg_addr == `SMBFL_A_CTRL) begin
                rd_d = {30'h0, off_q, unl_q};
            end else if (reg_addr == `SMBFL_A_STAT) begin
                rd_d = {8'h00, stat_q[2], stat_q[1], stat_q[0]};
            end else if (reg_addr == `SMBFL_A_SEQ) begin
                rd_d = {16'h0, seq_q[0]};
            end else if (reg_addr[9]
                         && reg_addr[7:6] != `SMBFL_TGT_NONE) begin
                rd_d = {24'h0, info_q[reg_addr[7:0]]};
            end
        end
        // link side
        if (rx.start) begin
            if (st_q == ST_IDLE) begin
                pec_d = 8'h00;
            end
            st_d = ST_ADR;
        end else if (rx.valid) begin
            pec_d = crc8(pec_q, rx.data);
            case (st_q)
                ST_ADR: begin
                    st_d = rx.data[0] ? ST_RD : ST_WR;
                    wi_d = 8'h00;
                    txi_d = 8'h00;
                    pwok_d = 1'b1;
                end
                ST_WR: begin
                    if (wi_q != 8'hFF) begin
                        wi_d = wi_q + 8'h01;
                    end
                    case (wi_q)
                        8'h00: cmd_d = rx.data;
                        8'h01: begin
                            tgt_d = rx.data;
                            pwok_d = (rx.data == `SMBFL_PW_LEN);
                        end
                        8'h02: a0_d = rx.data;
                        8'h03: a1_d = rx.data;
                        8'h04: begin
                            cnt_d = rx.data;
                            pcrc_d = crc_q[t];
                        end
                        default: ;
                    endcase
                    if (wi_q >= 8'h02 && wi_q <= 8'h05
                        && rx.data != pw_exp) begin
                        pwok_d = 1'b0;
                    end
                    if (cmd_q == `SMBFL_CMD_DATA && unl_q && wi_q > 8'h04
                        && wi_q < cnt_q + 8'h05) begin
                        pkt_d.valid = 1'b1;
                        pkt_d.data = rx.data;
                        pcrc_d = crc16(pcrc_q, rx.data);
                    end
                end
                default: ;
            endcase
        end else if (rx.stop) begin
            st_d = ST_IDLE;
            if (st_q == ST_WR) begin
                if (cmd_q == `SMBFL_CMD_PASS && pec_q == 8'h00
                    && wi_q == `SMBFL_WI_PASS && pwok_q) begin
                    unl_d = 1'b1;
                end
                if (cmd_q == `SMBFL_CMD_BOOT && unl_q
                    && pec_q == 8'h00
                    && wi_q == `SMBFL_WI_BOOT) begin
                    case (a0_q)
                        `SMBFL_BL_ENTER: begin
                            for (int k = 0; k < 3; k++) begin
                                stat_d[k] = stat_q[k] | `SMBFL_ST_BOOT;
                            end
                            sr_d = 1'b1;
                            off_d = off_q | on_s_q;
                        end
                        `SMBFL_BL_ERASE: begin
                            if (t != `SMBFL_TGT_NONE
                                && stat_q[t][7]) begin
                                stat_d[t] = (stat_q[t] & `SMBFL_ST_DOWN)
                                    | `SMBFL_ST_BOOT
                                    | `SMBFL_ST_ERASED;
                                seq_d[t] = 16'h0000;
                                crc_d[t] = `SMBFL_CRC_INIT;
                                ers_d = 1'b1;
                                etg_d = t;
                                off_d = off_q | on_s_q;
                            end
                        end
                        `SMBFL_BL_DONE: begin
                            if (t != `SMBFL_TGT_NONE) begin
                                stat_d[t] = (stat_q[t] & `SMBFL_ST_DOWN)
                                    | `SMBFL_ST_BOOT;
                                if (crc_q[t] != `SMBFL_CRC_INIT) begin
                                    stat_d[t] = stat_d[t]
                                        | `SMBFL_ST_CRCBAD
                                        | `SMBFL_ST_ERASED;
                                end
                            end
                        end
                        `SMBFL_BL_EXIT: begin
                            for (int k = 0; k < 3; k++) begin
                                if ((stat_q[k] & `SMBFL_ST_ERRS) == 8'h00) begin
                                    stat_d[k] = stat_q[k]
                                        & `SMBFL_ST_DOWN;
                                end
                            end
                            wd_d = 1'b1;
                            off_d = 1'b0;
                        end
                        default: ;
                    endcase
                end
                if (cmd_q == `SMBFL_CMD_DATA && unl_q) begin
                    pkt_d.abort = 1'b1;
                    if (pec_q == 8'h00
                        && wi_q == cnt_q + `SMBFL_WI_DHDR
                        && t != `SMBFL_TGT_NONE && stat_q[t][7]) begin
                        if ({a1_q, a0_q} != seq_q[t]) begin
                            stat_d[t] = stat_q[t] | `SMBFL_ST_SEQERR;
                        end else if (seq_q[t] >= MAX_PKTS) begin
                            stat_d[t] = stat_q[t] | `SMBFL_ST_RANGE;
                        end else begin
                            seq_d[t] = seq_q[t] + 16'h0001;
                            crc_d[t] = pcrc_q;
                            pkt_d.abort = 1'b0;
                            pkt_d.commit = 1'b1;
                        end
                    end
                end
            end
        end else if (tx_req && st_q == ST_RD) begin
            txd_d = (txi_q == last) ? pec_q : rb;
            txv_d = 1'b1;
            pec_d = crc8(pec_q, txd_d);
            if (txi_q != 8'hFF) begin
                txi_d = txi_q + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk) begin
        on_m_q <= output_on;
        on_s_q <= on_m_q;
        if (sys_rst) begin
            st_q <= ST_IDLE;
            for (int k = 0; k < 3; k++) begin
                stat_q[k] <= DOWN_MASK[k] ? `SMBFL_ST_DOWN : 8'h00;
                seq_q[k] <= 16'h0000;
                crc_q[k] <= `SMBFL_CRC_INIT;
            end
            pcrc_q <= `SMBFL_CRC_INIT;
            pec_q <= 8'h00;
            wi_q <= 8'h00;
            txi_q <= 8'h00;
            cmd_q <= 8'h00;
            tgt_q <= 8'h00;
            a0_q <= 8'h00;
            a1_q <= 8'h00;
            cnt_q <= 8'h00;
            pwok_q <= 1'b0;
            unl_q <= 1'b0;
            off_q <= 1'b0;
            txd_q <= 8'h00;
            txv_q <= 1'b0;
            ers_q <= 1'b0;
            etg_q <= 2'h0;
            sr_q <= 1'b0;
            wd_q <= 1'b0;
            pkt_q <= '0;
            rd_q <= 32'h0;
        end else begin
            st_q <= st_d;
            stat_q <= stat_d;
            seq_q <= seq_d;
            crc_q <= crc_d;
            pcrc_q <= pcrc_d;
            pec_q <= pec_d;
            wi_q <= wi_d;
            txi_q <= txi_d;
            cmd_q <= cmd_d;
            tgt_q <= tgt_d;
            a0_q <= a0_d;
            a1_q <= a1_d;
            cnt_q <= cnt_d;
            pwok_q <= pwok_d;
            unl_q <= unl_d;
            off_q <= off_d;
            txd_q <= txd_d;
            txv_q <= txv_d;
            ers_q <= ers_d;
            etg_q <= etg_d;
            sr_q <= sr_d;
            wd_q <= wd_d;
            pkt_q <= pkt_d;
            rd_q <= rd_d;
        end
    end

    // identity table is software content, not control state
    always_ff @(posedge mclk) begin
        info_q <= info_d;
    end

    assign tx_data = txd_q;
    assign tx_valid = txv_q;
    assign pkt = pkt_q;
    assign erase_req = ers_q;
    assign erase_tgt = etg_q;
    assign soft_reboot = sr_q;
    assign wdog_reboot = wd_q;
    assign output_off = off_q;
    assign reg_rdata = rd_q;
endmodule

// ==== testbench/smbfl_loader_chk.sv ====
`timescale 1ns/1ns
module smbfl_loader_chk
    import smbfl_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire smbfl_rx_t rx,
    input wire logic tx_req,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire smbfl_pkt_t pkt,
    input wire logic erase_req,
    input wire logic [1:0] erase_tgt,
    input wire logic soft_reboot,
    input wire logic wdog_reboot,
    input wire logic output_on,
    input wire logic output_off,
    input wire logic [9:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    property p_tx_ans;
        tx_req |=> tx_valid;
    endproperty
    a_tx_ans: assert property (p_tx_ans) else $error("read byte late");
    property p_tx_cause;
        tx_valid |-> $past(tx_req) ##1 !tx_valid || $past(tx_req, 1);
    endproperty
    a_tx_cause: assert property (p_tx_cause) else $error("stray byte");
    property p_erase;
        erase_req |-> $past(rx.stop) ##1 !erase_req;
    endproperty
    a_erase: assert property (p_erase) else $error("erase pulse");
    property p_enter;
        soft_reboot |-> $past(rx.stop) && !wdog_reboot ##1 !soft_reboot;
    endproperty
    a_enter: assert property (p_enter) else $error("enter pulse");
    property p_exit;
        wdog_reboot |-> $past(rx.stop) ##1 !wdog_reboot;
    endproperty
    a_exit: assert property (p_exit) else $error("exit pulse");
    property p_verdict;
        pkt.commit || pkt.abort |-> $past(rx.stop) && !(pkt.commit && pkt.abort);
    endproperty
    a_verdict: assert property (p_verdict) else $error("packet verdict");
    property p_byte;
        pkt.valid |-> $past(rx.valid) && pkt.data == $past(rx.data);
    endproperty
    a_byte: assert property (p_byte) else $error("packet byte");
    property p_off;
        $rose(output_off) |-> $past(rx.stop);
    endproperty
    a_off: assert property (p_off) else $error("output off cause");
    property p_rdata;
        reg_rdata != 32'h0 |-> $past(reg_rd);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data stands");
    c_commit: cover property (pkt.commit);
    c_abort: cover property (pkt.abort);
    c_erase: cover property (erase_req);
endmodule
bind smbfl_loader smbfl_loader_chk u_chk (.mclk(mclk), .sys_rst(sys_rst),
    .rx(rx), .tx_req(tx_req), .tx_data(tx_data), .tx_valid(tx_valid),
    .pkt(pkt), .erase_req(erase_req), .erase_tgt(erase_tgt),
    .soft_reboot(soft_reboot), .wdog_reboot(wdog_reboot),
    .output_on(output_on), .output_off(output_off), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

// ==== testbench/smbfl_host.sv ====
`timescale 1ns/1ns
`include "smbfl_consts.svh"
module smbfl_host
    import smbfl_pkg::*;
#(
    parameter logic [7:0] ADDR = 8'hB0
) (
    input wire logic mclk,
    output smbfl_rx_t rx,
    output logic tx_req,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid
);
    logic [7:0] crc;
    initial begin
        rx = '0;
        tx_req = 1'b0;
    end
    // pec: crc-8, poly 0x07, over every byte on the wire
    function automatic logic [7:0] crc8(input logic [7:0] b);
        logic [7:0] r;
        r = crc ^ b;
        for (int k = 0; k < 8; k++) begin
            r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
        end
        return r;
    endfunction
    // f: start, stop, valid
    task automatic pulse(input logic [2:0] f, input logic [7:0] d);
        @(posedge mclk);
        rx <= {f, d};
        @(posedge mclk);
        rx <= {3'h0, ~d};
        if (f[0]) crc = crc8(d);
    endtask
    task automatic wr(input logic [7:0] b[$], input logic bad);
        crc = 8'h00;
        pulse(3'h4, 8'h00);
        pulse(3'h1, ADDR);
        foreach (b[k]) pulse(3'h1, b[k]);
        pulse(3'h1, crc ^ {7'h00, bad});
        pulse(3'h2, 8'h00);
    endtask
    // upgrade steps are followed by a status or sequence read back, except the locked enter, the second erase and the packet after it
    task automatic rd(input logic [7:0] c, t, input int n,
                      output logic [7:0] q[$], output logic ok);
        crc = 8'h00;
        q = {};
        pulse(3'h4, 8'h00);
        pulse(3'h1, ADDR);
        pulse(3'h1, c);
        if (c != `SMBFL_CMD_TLIST && c != `SMBFL_CMD_DATA) pulse(3'h1, t);
        pulse(3'h4, 8'h00);
        pulse(3'h1, ADDR | 8'h01);
        repeat (n + 1) begin
            @(posedge mclk);
            tx_req <= 1'b1;
            @(posedge mclk);
            tx_req <= 1'b0;
            #1;
            q.push_back(tx_valid ? tx_data : 8'hXX);
            crc = crc8(q[$]);
        end
        ok = crc == 8'h00;
        pulse(3'h2, 8'h00);
    endtask
endmodule

// ==== testbench/smbfl_loader_tb.sv ====
`timescale 1ns/1ns
`include "smbfl_consts.svh"
module smbfl_loader_tb
    import smbfl_pkg::*;
;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic output_on = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [9:0] reg_addr = 10'h000;
    logic [31:0] reg_wdata = 32'h0;
    smbfl_rx_t rx;
    smbfl_pkt_t pkt;
    logic tx_req, tx_valid, erase_req, soft_reboot, wdog_reboot, output_off;
    logic [7:0] tx_data;
    logic [1:0] erase_tgt;
    logic [31:0] reg_rdata;
    int fail_count = 0;
    int num_checks = 0;
    logic [7:0] st [3] = '{8'h00, 8'h00, 8'h00};
    logic [15:0] seq = 16'h0000;
    logic [7:0] got [$];
    logic pec_ok;
    // command, target, first byte returned
    logic [23:0] rows [8] = '{24'hE17003, 24'hE27020, 24'hE37307,
        24'hE46907, 24'hE57000, 24'hE56900, 24'hE77003, 24'hE37AFF};
    always #5 mclk = ~mclk;
    smbfl_loader #(.DOWN_MASK(3'h0), .MAX_PKTS(16'h0004)) u_dut (
        .mclk(mclk), .sys_rst(sys_rst), .rx(rx), .tx_req(tx_req),
        .tx_data(tx_data), .tx_valid(tx_valid), .pkt(pkt),
        .erase_req(erase_req), .erase_tgt(erase_tgt),
        .soft_reboot(soft_reboot), .wdog_reboot(wdog_reboot),
        .output_on(output_on), .output_off(output_off), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    smbfl_host u_host (.mclk(mclk), .rx(rx), .tx_req(tx_req),
        .tx_data(tx_data), .tx_valid(tx_valid));
    function automatic logic [7:0] info(input int t, input int i);
        return 8'(t * 64 + i) ^ 8'hA5;
    endfunction
    function automatic int tix(input logic [7:0] c);
        return c == 8'h70 ? 0 : c == 8'h73 ? 1 : c == 8'h69 ? 2 : 3;
    endfunction
    function automatic int nbytes(input logic [7:0] c);
        return c == 8'hE2 ? 33 : c == 8'hE5 ? 1 : c == 8'hE1 ? 4 :
            c == 8'hE7 ? 4 : 8;
    endfunction
    // bit 8 marks a byte that is not compared
    function automatic logic [8:0] exp_rd(input logic [7:0] c, input int t,
                                          input int i);
        logic [7:0] tl [3] = '{8'h70, 8'h73, 8'h69};
        if (c == 8'hE1) return i == 0 ? 9'h003 : {1'b0, tl[i - 1]};
        if (c == 8'hE7) t = 0;
        if (t == 3) return 9'h0FF;
        case (c)
            8'hE2: return i == 0 ? 9'h020 : {1'b0, info(t, i - 1)};
            8'hE3: return i == 0 ? 9'h007 : {1'b0, info(t, 31 + i)};
            8'hE4: return i == 0 ? 9'h007 : i < 6 ? {1'b0, info(t, 38 + i)}
                : 9'h000;
            8'hE5: return {1'b0, st[t]};
            default: return i == 0 ? 9'h003 : i == 1 ? {1'b0, seq[7:0]} :
                i == 2 ? {1'b0, seq[15:8]} : {1'b0, st[0]};
        endcase
    endfunction
    task automatic chk(input logic [31:0] g, e);
        num_checks++;
        if (g !== e) begin
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
            fail_count++;
        end
    endtask
    task automatic wrap_up();
        if (fail_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic reg_w(input logic [9:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= {24'h000000, d};
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_r(input logic [9:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask
    task automatic query(input logic [7:0] c, t);
        logic [8:0] e;
        u_host.rd(c, t, nbytes(c), got, pec_ok);
        chk(32'(pec_ok), 32'h1);
        for (int i = 0; i < nbytes(c); i++) begin
            e = exp_rd(c, tix(t), i);
            if (!e[8]) chk(32'(got[i]), 32'(e[7:0]));
        end
    endtask
    task automatic boot(input logic [7:0] t, d);
        u_host.wr({`SMBFL_CMD_BOOT, t, d}, 1'b0);
        #1;
    endtask
    task automatic dpkt(input logic [15:0] s, input logic bad);
        u_host.wr({`SMBFL_CMD_DATA, 8'h70, s[7:0], s[15:8], 8'h02, 8'h00,
            8'h00}, bad);
        #1;
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        #1;
        chk(32'(pkt), 32'h0);
        chk(32'({tx_valid, erase_req, soft_reboot, wdog_reboot, output_off}),
            32'h0);
        @(posedge mclk);
        sys_rst <= 1'b0;
        reg_r(`SMBFL_A_CTRL, 32'h0);
        reg_r(`SMBFL_A_STAT, 32'h0);
        reg_r(10'h3FC, 32'h0);
        for (int t = 0; t < 3; t++)
            for (int i = 0; i < 44; i++)
                reg_w(10'(10'h200 + t * 64 + i), info(t, i));
        reg_r(10'h26B, 32'(info(1, 43)));
        foreach (rows[r]) begin
            query(rows[r][23:16], rows[r][15:8]);
            chk(32'(got[0]), 32'(rows[r][7:0]));
        end
        boot(8'h70, `SMBFL_BL_ENTER);
        chk(32'(soft_reboot), 32'h0);
        u_host.wr({8'hE0, 8'h04, 8'h55, 8'h50, 8'h47, 8'h44}, 1'b1);
        reg_r(`SMBFL_A_CTRL, 32'h0);
        u_host.wr({8'hE0, 8'h04, 8'h55, 8'h50, 8'h47, 8'h44}, 1'b0);
        reg_r(`SMBFL_A_CTRL, 32'h1);
        @(posedge mclk);
        output_on <= 1'b1;
        repeat (3) @(posedge mclk);
        boot(8'h7A, `SMBFL_BL_ENTER);
        chk(32'(soft_reboot), 32'h1);
        st = '{8'h80, 8'h80, 8'h80};
        reg_r(`SMBFL_A_STAT, 32'h00808080);
        reg_r(`SMBFL_A_CTRL, 32'h3);
        chk(32'(output_off), 32'h1);
        boot(8'h70, `SMBFL_BL_ERASE);
        chk(32'({erase_req, erase_tgt}), 32'h4);
        repeat (100) @(posedge mclk);
        st[0] = 8'h81;
        query(8'hE5, 8'h70);
        dpkt(16'h0000, 1'b0);
        chk(32'({pkt.commit, pkt.abort}), 32'h2);
        seq = 16'h0001;
        query(8'hE7, 8'h70);
        reg_r(`SMBFL_A_SEQ, 32'h1);
        dpkt(16'h0001, 1'b1);
        chk(32'({pkt.commit, pkt.abort}), 32'h1);
        chk(32'({pkt.tgt, pkt.seq}), 32'h1);
        query(8'hE7, 8'h70);
        dpkt(16'h0005, 1'b0);
        chk(32'({pkt.commit, pkt.abort}), 32'h1);
        st[0] = 8'h85;
        query(8'hE7, 8'h70);
        boot(8'h70, `SMBFL_BL_ERASE);
        repeat (100) @(posedge mclk);
        dpkt(16'h0000, 1'b0);
        chk(32'({pkt.commit, pkt.abort}), 32'h2);
        boot(8'h70, `SMBFL_BL_DONE);
        st[0] = 8'h80;
        query(8'hE5, 8'h70);
        boot(8'h7A, `SMBFL_BL_EXIT);
        chk(32'(wdog_reboot), 32'h1);
        st = '{8'h00, 8'h00, 8'h00};
        reg_r(`SMBFL_A_STAT, 32'h0);
        reg_r(`SMBFL_A_CTRL, 32'h1);
        reg_w(`SMBFL_A_CTRL, 8'h01);
        reg_r(`SMBFL_A_CTRL, 32'h0);
        wrap_up();
    end
endmodule
